// [design/tct_conv.sv]
// Conversion sequencer: times each conversion, stores masked result.
// Assumes sensor_temp is valid on clk whenever a conversion ends.
`timescale 1ns/1ps
`default_nettype none
`include "tct_regs.svh"
module tct_conv import tct_pkg::*;
#(
   parameter int unsigned CONV9_CYCLES = `TCT_CONV9_CYCLES
)
(
   input  wire logic        clk,         // Core clock
   input  wire logic        rst_n,       // Synchronous reset, low
   input  wire logic        start,       // Begin conversions, pulse
   input  wire logic        one_shot,    // Single conversion mode
   input  wire logic [1:0]  res,         // Resolution code
   input  wire logic [15:0] res_mask,    // Bits kept at resolution
   input  wire logic [15:0] sensor_temp, // Front-end reading
   output logic             busy,        // Conversion in progress
   output logic             done,        // Result updated, pulse
   output logic      [15:0] result       // Last completed result
);
   localparam logic [`TCT_CONV_CNT_W-1:0] BASE =
      `TCT_CONV_CNT_W'(CONV9_CYCLES);
   tct_conv_state_type st;
   logic [`TCT_CONV_CNT_W-1:0] cnt;
   wire  [`TCT_CONV_CNT_W-1:0] span = BASE << res;

   assign busy = (st == TCT_RUN);

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st     <= TCT_IDLE;
         cnt    <= '0;
         done   <= 1'b0;
         result <= 16'h0000;
      end
      else
      begin
         done <= 1'b0;
         case (st)
            TCT_IDLE:
               if (start)
               begin
                  st  <= TCT_RUN;
                  cnt <= span;
               end
            default:
               if (cnt <= 1)
               begin
                  result <= sensor_temp & res_mask;
                  done   <= 1'b1;
                  if (one_shot)
                     st <= TCT_IDLE;
                  else
                     cnt <= span;
               end
               else
                  cnt <= cnt - 1'b1;
         endcase
      end
   end

   sequence s_cont_end;
      done && !one_shot;
   endsequence
   a_one_shot_stop: assert property (@(posedge clk) disable iff (!rst_n)
      done && one_shot && !start |-> !busy)
      else $error("single conversion did not stop");
   a_cont_repeat: assert property (@(posedge clk) disable iff (!rst_n)
      s_cont_end |-> busy ##1 busy)
      else $error("continuous conversions stopped");
   a_res_zero: assert property (@(posedge clk) disable iff (!rst_n)
      done |-> (result & ~$past(res_mask)) == 16'h0000 && result[3:0] == 4'h0)
      else $error("bits below resolution not zero");
   a_start_begins: assert property (@(posedge clk) disable iff (!rst_n)
      start && !busy |=> busy ##1 (busy || done))
      else $error("start did not begin a conversion");
endmodule
`default_nettype wire

// [design/tct_pkg.sv]
// Types shared by the conversion and thermostat block.
// Assumes nothing beyond a SystemVerilog compiler.
package tct_pkg;
   typedef enum logic {TCT_IDLE, TCT_RUN} tct_conv_state_type;
   typedef enum logic [2:0] {TCT_L_IDLE, TCT_L_ADDR, TCT_L_CMD,
                             TCT_L_WR, TCT_L_RD} tct_link_state_type;
endpackage

// [design/tct_regs.svh]
// Constants for the temperature conversion and thermostat block.
// Assumes a 40 MHz core clock; included by bare name.
`ifndef TCT_REGS_SVH
`define TCT_REGS_SVH
`define TCT_CMD_START    8'h51
`define TCT_CMD_RD_TEMP  8'hAA
`define TCT_CMD_CFG      8'hAC
`define TCT_CMD_HIGH     8'hA1
`define TCT_CMD_LOW      8'hA2
`define TCT_DEV_FAMILY   4'h9
`define TCT_CFG_ONESHOT  0
`define TCT_CFG_POL      1
`define TCT_CFG_RES_LO   2
`define TCT_CFG_RES_HI   3
`define TCT_CFG_FLAG_LO  5
`define TCT_CFG_FLAG_HI  6
`define TCT_HIGH_RST     16'h5000
`define TCT_LOW_RST      16'h4B00
`define TCT_RES_RST      2'h3
`define TCT_POL_RST      1'h1
`define TCT_ONESHOT_RST  1'h0
`define TCT_CLK_HZ       40000000
`define TCT_CONV9_MS     150
`define TCT_CONV9_CYCLES (`TCT_CONV9_MS * (`TCT_CLK_HZ / 1000))
`define TCT_CONV_CNT_W   26
`endif

// [design/tct_sync.sv]
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level or a toggle, never a bus word.
`timescale 1ns/1ps
`default_nettype none
module tct_sync import tct_pkg::*;
#(
   parameter int W = 1
)
(
   input  wire logic         clk,   // Destination clock
   input  wire logic [W-1:0] d,     // Asynchronous levels
   output logic      [W-1:0] q      // Synchronised levels
);
   logic [W-1:0] meta;

   always_ff @(posedge clk)
   begin
      meta <= d;
      q    <= meta;
   end
endmodule
`default_nettype wire

// [design/tct_top.sv]
// Temperature conversion, setpoints and thermostat with serial slave.
// Assumes link_clk runs free and far faster than the serial clock;
// sensor_temp comes from the converter front end on clk.
`timescale 1ns/1ps
`default_nettype none
`include "tct_regs.svh"
module tct_top import tct_pkg::*;
#(
   parameter int unsigned CONV9_CYCLES = `TCT_CONV9_CYCLES
)
(
   input  wire logic        clk,              // Core clock, 40 MHz
   input  wire logic        rst_n,            // Synchronous reset, low
   input  wire logic        link_clk,         // Serial sampling clock
   input  wire logic        scl_in,           // Serial clock pin level
   output logic             scl_out,          // Never driven low
   output logic             scl_oe,           // Never enabled
   input  wire logic        sda_in,           // Serial data pin level
   output logic             sda_out,          // Drive value, always 0
   output logic             sda_oe,           // High pulls data low
   input  wire logic        addr_strap_0,     // Address strap bit 0
   input  wire logic        addr_strap_1,     // Address strap bit 1
   input  wire logic        addr_strap_2,     // Address strap bit 2
   input  wire logic [15:0] sensor_temp,      // Front-end reading
   output logic             thermo_alarm_out  // Thermostat output
);
   // Link domain
   logic        lrst_n, scl_s, sda_s, pub_tog_s;
   logic [2:0]  strap_s;
   logic        prev_scl, prev_sda;
   tct_link_state_type st;
   logic [3:0]  bit_cnt;
   logic [7:0]  shift, out_shift, cmd, wr_kind;
   logic        byte_idx, ack_pend, wr_tog, ack_tog;
   logic [15:0] wr_hold, l_temp, l_th, l_tl, rd_hold;
   logic [7:0]  l_cfg;
   // Core domain
   logic        wr_tog_s, ack_tog_s, wr_seen, pub_tog;
   logic        one_shot, alarm_polarity, u_bit, flag_hi, flag_lo, alarm;
   logic [1:0]  res;
   logic [15:0] high_trip_setpoint, low_trip_setpoint;
   logic [15:0] pub_temp, pub_th, pub_tl;
   logic [7:0]  pub_cfg;
   logic        busy, conv_done;
   logic [15:0] conv_result;

   tct_sync #(.W(7)) u_lsync
   (
      .clk (link_clk),
      .d   ({rst_n, scl_in, sda_in, pub_tog,
             addr_strap_2, addr_strap_1, addr_strap_0}),
      .q   ({lrst_n, scl_s, sda_s, pub_tog_s, strap_s})
   );

   wire scl_rise = scl_s & ~prev_scl;
   wire scl_fall = ~scl_s & prev_scl;
   wire start_c  = scl_s & prev_scl & prev_sda & ~sda_s;
   wire stop_c   = scl_s & prev_scl & ~prev_sda & sda_s;
   wire [7:0] in_byte = {shift[6:0], sda_s};
   wire addr_hit = in_byte[7:1] == {`TCT_DEV_FAMILY, strap_s};
   wire byte_end = scl_rise && bit_cnt == 4'd7;
   wire [15:0] rd_word =
      (cmd == `TCT_CMD_RD_TEMP) ? l_temp :
      (cmd == `TCT_CMD_HIGH)    ? l_th   :
      (cmd == `TCT_CMD_LOW)     ? l_tl   :
      (cmd == `TCT_CMD_CFG)     ? {l_cfg, 8'hFF} : 16'hFFFF;

   always_ff @(posedge link_clk)
   begin
      prev_scl <= scl_s;
      prev_sda <= sda_s;
   end

   // Serial slave sequencing, one bit per rising serial clock
   always_ff @(posedge link_clk)
   begin
      if (!lrst_n)
      begin
         st        <= TCT_L_IDLE;
         bit_cnt   <= 4'h0;
         shift     <= 8'h00;
         out_shift <= 8'hFF;
         cmd       <= 8'h00;
         byte_idx  <= 1'b0;
         ack_pend  <= 1'b0;
      end
      else if (start_c)
      begin
         st       <= TCT_L_ADDR;
         bit_cnt  <= 4'h0;
         ack_pend <= 1'b0;
      end
      else if (stop_c)
      begin
         st       <= TCT_L_IDLE;
         ack_pend <= 1'b0;
      end
      else if (scl_rise && st != TCT_L_IDLE)
      begin
         if (bit_cnt == 4'd8)
         begin
            bit_cnt  <= 4'h0;
            ack_pend <= 1'b0;
            if (st == TCT_L_RD)
            begin
               // Master not acknowledging ends the read
               if (sda_s)
                  st <= TCT_L_IDLE;
               out_shift <= byte_idx ? rd_hold[15:8] : rd_hold[7:0];
               byte_idx  <= ~byte_idx;
            end
         end
         else
         begin
            bit_cnt   <= bit_cnt + 4'd1;
            shift     <= in_byte;
            out_shift <= {out_shift[6:0], 1'b1};
            if (bit_cnt == 4'd7)
            begin
               case (st)
                  TCT_L_ADDR:
                     if (!addr_hit)
                        st <= TCT_L_IDLE;
                     else
                     begin
                        ack_pend <= 1'b1;
                        // Address ack bit of a read reloads the high byte
                        byte_idx <= in_byte[0];
                        if (in_byte[0])
                        begin
                           st        <= TCT_L_RD;
                           rd_hold   <= rd_word;
                           out_shift <= rd_word[15:8];
                        end
                        else
                           st <= TCT_L_CMD;
                     end
                  TCT_L_CMD:
                  begin
                     ack_pend <= 1'b1;
                     cmd      <= in_byte;
                     byte_idx <= 1'b0;
                     st       <= TCT_L_WR;
                  end
                  TCT_L_WR:
                  begin
                     ack_pend <= 1'b1;
                     byte_idx <= 1'b1;
                  end
                  default:
                     ack_pend <= 1'b0;
               endcase
            end
         end
      end
   end

   // Hand write events to the core: data held, toggle flips on the same edge
   always_ff @(posedge link_clk)
   begin
      if (!lrst_n)
      begin
         wr_tog  <= 1'b0;
         wr_kind <= 8'h00;
         wr_hold <= 16'h0000;
      end
      else if (byte_end && st == TCT_L_CMD && in_byte == `TCT_CMD_START)
      begin
         wr_kind <= in_byte;
         wr_tog  <= ~wr_tog;
      end
      else if (byte_end && st == TCT_L_WR && !byte_idx)
      begin
         wr_hold <= {in_byte, 8'h00};
         wr_kind <= cmd;
         if (cmd == `TCT_CMD_CFG)
            wr_tog <= ~wr_tog;
      end
      else if (byte_end && st == TCT_L_WR && byte_idx)
      begin
         wr_hold[7:0] <= in_byte;
         if (cmd == `TCT_CMD_HIGH || cmd == `TCT_CMD_LOW)
            wr_tog <= ~wr_tog;
      end
   end

   // Data line drive changes on a falling serial clock; start, stop and reset release it
   always_ff @(posedge link_clk)
   begin
      if (!lrst_n || start_c || stop_c)
         sda_oe <= 1'b0;
      else if (scl_fall)
         sda_oe <= (bit_cnt == 4'd8) ? ack_pend
                 : (st == TCT_L_RD && !out_shift[7]);
   end

   assign sda_out = 1'b0;
   assign scl_out = 1'b0;
   assign scl_oe  = 1'b0;

   // Snapshot words arrive whole under the toggle handshake
   always_ff @(posedge link_clk)
   begin
      if (!lrst_n)
      begin
         ack_tog <= 1'b0;
         l_temp  <= 16'h0000;
         l_cfg   <= 8'h00;
         l_th    <= `TCT_HIGH_RST;
         l_tl    <= `TCT_LOW_RST;
      end
      else if (pub_tog_s != ack_tog)
      begin
         l_temp  <= pub_temp;
         l_cfg   <= pub_cfg;
         l_th    <= pub_th;
         l_tl    <= pub_tl;
         ack_tog <= pub_tog_s;
      end
   end

   // Core domain
   tct_sync #(.W(2)) u_csync
   (
      .clk (clk),
      .d   ({wr_tog, ack_tog}),
      .q   ({wr_tog_s, ack_tog_s})
   );

   wire wr_ev     = wr_tog_s != wr_seen;
   wire start_cmd = wr_ev && wr_kind == `TCT_CMD_START;
   wire cfg_wr    = wr_ev && wr_kind == `TCT_CMD_CFG;
   wire th_wr     = wr_ev && wr_kind == `TCT_CMD_HIGH;
   wire tl_wr     = wr_ev && wr_kind == `TCT_CMD_LOW;
   wire [7:0] cfg_in = wr_hold[15:8];
   wire [15:0] res_mask = (res == 2'h0) ? 16'hFF80 :
                          (res == 2'h1) ? 16'hFFC0 :
                          (res == 2'h2) ? 16'hFFE0 : 16'hFFF0;
   wire hit_hi = $signed(conv_result) >=
                 $signed(high_trip_setpoint & res_mask);
   wire hit_lo = $signed(conv_result) <=
                 $signed(low_trip_setpoint & res_mask);
   wire next_alarm = !conv_done ? alarm :
                     hit_hi ? 1'b1 :
                     hit_lo ? 1'b0 : alarm;
   wire [7:0] cfg_byte = {~busy, flag_hi, flag_lo, u_bit,
                          res, alarm_polarity, one_shot};

   tct_conv #(.CONV9_CYCLES(CONV9_CYCLES)) u_conv
   (
      .clk         (clk),
      .rst_n       (rst_n),
      .start       (start_cmd),
      .one_shot    (one_shot),
      .res         (res),
      .res_mask    (res_mask),
      .sensor_temp (sensor_temp),
      .busy        (busy),
      .done        (conv_done),
      .result      (conv_result)
   );

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wr_seen  <= wr_tog_s; // Stale toggle is no event
         one_shot <= `TCT_ONESHOT_RST;
         alarm_polarity      <= `TCT_POL_RST;
         res      <= `TCT_RES_RST;
         u_bit    <= 1'b0;
      end
      else
      begin
         wr_seen <= wr_tog_s;
         if (start_cmd)
            u_bit <= 1'b1;
         if (cfg_wr)
         begin
            one_shot <= cfg_in[`TCT_CFG_ONESHOT];
            alarm_polarity      <= cfg_in[`TCT_CFG_POL];
            res      <= cfg_in[`TCT_CFG_RES_HI:`TCT_CFG_RES_LO];
         end
      end
   end

   // Sticky trip flags: a trip in the clearing cycle still sets
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         flag_hi <= 1'b0;
         flag_lo <= 1'b0;
      end
      else
      begin
         flag_hi <= (conv_done && hit_hi) ||
                    (flag_hi && !(cfg_wr && !cfg_in[`TCT_CFG_FLAG_HI]));
         flag_lo <= (conv_done && hit_lo) ||
                    (flag_lo && !(cfg_wr && !cfg_in[`TCT_CFG_FLAG_LO]));
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         high_trip_setpoint <= `TCT_HIGH_RST;
         low_trip_setpoint  <= `TCT_LOW_RST;
      end
      else
      begin
         if (th_wr)
            high_trip_setpoint <= wr_hold;
         if (tl_wr)
            low_trip_setpoint <= wr_hold;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         alarm            <= 1'b0;
         thermo_alarm_out <= 1'b0 ~^ `TCT_POL_RST;
      end
      else
      begin
         alarm            <= next_alarm;
         thermo_alarm_out <= next_alarm ~^ alarm_polarity;
      end
   end

   // Publish a fresh snapshot each handshake round; reads only see
   // copies, so the conversion itself is never touched
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         pub_tog  <= 1'b0;
         pub_temp <= 16'h0000;
         pub_cfg  <= 8'h00;
         pub_th   <= `TCT_HIGH_RST;
         pub_tl   <= `TCT_LOW_RST;
      end
      else if (pub_tog == ack_tog_s)
      begin
         pub_temp <= conv_result;
         pub_cfg  <= cfg_byte;
         pub_th   <= high_trip_setpoint;
         pub_tl   <= low_trip_setpoint;
         pub_tog  <= ~pub_tog;
      end
   end

   a_idle_powerup: assert property (@(posedge clk) disable iff (!rst_n)
      !u_bit |-> !busy && !conv_done)
      else $error("conversion ran before start command");
   a_alarm_set: assert property (@(posedge clk) disable iff (!rst_n)
      conv_done && hit_hi |=> alarm && thermo_alarm_out == alarm_polarity)
      else $error("alarm not raised at high setpoint");
   a_alarm_clear: assert property (@(posedge clk) disable iff (!rst_n)
      conv_done && !hit_hi && hit_lo |=> !alarm)
      else $error("alarm not released at low setpoint");
   a_alarm_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !conv_done |=> alarm == $past(alarm))
      else $error("alarm changed without a conversion");
   a_pub_stable: assert property (@(posedge clk) disable iff (!rst_n)
      pub_tog != ack_tog_s |=> $stable(pub_temp))
      else $error("snapshot changed during handshake");
   a_addr_ignore: assert property (@(posedge link_clk)
      disable iff (!lrst_n)
      byte_end && st == TCT_L_ADDR && !addr_hit && !start_c && !stop_c
      |=> !ack_pend && st == TCT_L_IDLE)
      else $error("foreign address acknowledged");
endmodule
`default_nettype wire

// [sim/tct_mst.sv]
// Two-wire bus master model facing the serial slave of the block.
// Assumes pull-ups on both lines; the bench resolves wired levels.
`timescale 1ns/1ps
`default_nettype none
module tct_mst import tct_pkg::*;
(
   input  wire logic clk,      // Bench clock, paces bit timing
   input  wire logic sda,      // Resolved data line level
   output logic      scl_pull, // High pulls the clock line low
   output logic      sda_pull  // High pulls the data line low
);
   initial
   begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end

   // Quarter bit of 25 cycles keeps the clock at 400 kHz
   task automatic q();
      repeat (25) @(posedge clk);
   endtask

   task automatic st();
      sda_pull <= 1'b0;
      q();
      scl_pull <= 1'b0;
      q();
      sda_pull <= 1'b1;
      q();
      scl_pull <= 1'b1;
      q();
   endtask

   task automatic sp();
      sda_pull <= 1'b1;
      q();
      scl_pull <= 1'b0;
      q();
      sda_pull <= 1'b0;
      q();
   endtask

   // Data changes only while the clock line is low
   task automatic bit_io(input logic b, output logic s);
      sda_pull <= !b;
      q();
      scl_pull <= 1'b0;
      q();
      s = sda;
      q();
      scl_pull <= 1'b1;
      q();
   endtask

   task automatic byte_io(input logic [7:0] b, input logic last,
                          output logic [7:0] r, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
         bit_io(b[i], r[i]);
      bit_io(last, s);
      ack = !s;
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] cmd,
                     input int n, input logic [15:0] d, output logic ok);
      logic [7:0] r;
      logic       k;
      st();
      byte_io({a, 1'b0}, 1'b1, r, ok);
      byte_io(cmd, 1'b1, r, k);
      ok = ok & k;
      for (int i = 0; i < n; i++)
      begin
         byte_io((n == 2 && i == 0) ? d[15:8] : d[7:0], 1'b1, r, k);
         ok = ok & k;
      end
      sp();
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] cmd,
                     input int n, output logic [15:0] d);
      logic [7:0] r;
      logic       k;
      st();
      byte_io({a, 1'b0}, 1'b1, r, k);
      byte_io(cmd, 1'b1, r, k);
      st();
      byte_io({a, 1'b1}, 1'b1, r, k);
      d = 16'h0000;
      for (int i = 0; i < n; i++)
      begin
         byte_io(8'hFF, i == n - 1, r, k);
         d = {d[7:0], r};
      end
      sp();
   endtask
endmodule
`default_nettype wire

// [sim/tct_tb_top.sv]
// Self-checking bench: bus master model, sensor stimulus, alarm pin.
// Assumes the design header and package compile first.
`timescale 1ns/1ps
`default_nettype none
`include "tct_regs.svh"
module tct_tb_top import tct_pkg::*; ;
   localparam int unsigned CONV9 = 20;
   localparam logic [6:0] DEV = {`TCT_DEV_FAMILY, 3'b101};
   logic        clk;
   logic        link_clk;
   logic        rst_n;
   logic [2:0]  strap;
   logic [15:0] temp;
   logic        scl_pull;
   logic        sda_pull;
   logic        scl_oe;
   logic        sda_oe;
   logic        alarm;
   logic        scl_dv;
   logic        sda_dv;
   wire logic   scl_w;
   wire logic   sda_w;
   int          error_cnt;
   int          total_checks;

   assign scl_w = !(scl_pull | scl_oe);
   assign sda_w = !(sda_pull | sda_oe);

   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      link_clk = 1'b0;
      #7;
      forever #40 link_clk = ~link_clk;
   end

   tct_top #(.CONV9_CYCLES(CONV9)) i_dut (
      .clk(clk), .rst_n(rst_n), .link_clk(link_clk),
      .scl_in(scl_w), .scl_out(scl_dv), .scl_oe(scl_oe),
      .sda_in(sda_w), .sda_out(sda_dv), .sda_oe(sda_oe),
      .addr_strap_0(strap[0]), .addr_strap_1(strap[1]),
      .addr_strap_2(strap[2]), .sensor_temp(temp),
      .thermo_alarm_out(alarm));

   tct_mst i_mst (.clk(clk), .sda(sda_w), .scl_pull(scl_pull),
                  .sda_pull(sda_pull));

   task automatic chk_word(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_bit(input string what, input logic exp,
                          input logic got);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // Six core cycles still span a link edge; link reset follows in sync
   task automatic do_reset();
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (20) @(posedge clk);
   endtask

   task automatic t_defaults();
      logic [15:0] d;
      chk_bit("alarm at reset", 1'b0, alarm);
      chk_bit("clock drive value", 1'b0, scl_dv);
      chk_bit("data drive value", 1'b0, sda_dv);
      i_mst.rd(DEV, `TCT_CMD_CFG, 1, d);
      chk_word("config", 16'h008E, d);
      i_mst.rd(DEV, `TCT_CMD_HIGH, 2, d);
      chk_word("high setpoint", 16'h5000, d);
      i_mst.rd(DEV, `TCT_CMD_LOW, 2, d);
      chk_word("low setpoint", 16'h4B00, d);
   endtask

   task automatic t_address();
      logic        ok;
      logic [15:0] d;
      i_mst.wr(DEV ^ 7'h01, `TCT_CMD_START, 0, 16'h0000, ok);
      chk_bit("foreign ack", 1'b0, ok);
      repeat (400) @(posedge clk);
      i_mst.rd(DEV, `TCT_CMD_RD_TEMP, 2, d);
      chk_word("idle result", 16'h0000, d);
   endtask

   task automatic t_single();
      logic        ok;
      logic [15:0] d;
      i_mst.wr(DEV, `TCT_CMD_CFG, 1, 16'h0001, ok);
      chk_bit("config ack", 1'b1, ok);
      repeat (10) @(posedge clk);
      chk_bit("alarm idle level", 1'b1, alarm);
      temp <= 16'hF5E0;
      i_mst.wr(DEV, `TCT_CMD_START, 0, 16'h0000, ok);
      repeat (40) @(posedge clk);
      temp <= 16'h0A20;
      i_mst.rd(DEV, `TCT_CMD_RD_TEMP, 2, d);
      chk_word("nine bit", 16'hF580, d);
      i_mst.rd(DEV, `TCT_CMD_CFG, 1, d);
      chk_word("single status", 16'h00B1, d);
      i_mst.wr(DEV, `TCT_CMD_HIGH, 2, 16'hFF00, ok);
      chk_bit("alarm still idle", 1'b1, alarm);
      i_mst.wr(DEV, `TCT_CMD_START, 0, 16'h0000, ok);
      repeat (40) @(posedge clk);
      chk_bit("alarm active", 1'b0, alarm);
   endtask

   task automatic t_again();
      logic [15:0] d;
      do_reset();
      chk_bit("alarm after reset", 1'b0, alarm);
      i_mst.rd(DEV, `TCT_CMD_CFG, 1, d);
      chk_word("config after reset", 16'h008E, d);
   endtask

   task automatic t_resolution();
      logic        ok;
      logic [15:0] d;
      logic [15:0] m;
      temp <= 16'h19F7;
      i_mst.wr(DEV, `TCT_CMD_START, 0, 16'h0000, ok);
      repeat (400) @(posedge clk);
      i_mst.rd(DEV, `TCT_CMD_RD_TEMP, 2, d);
      chk_word("default result", 16'h19F0, d);
      i_mst.rd(DEV, `TCT_CMD_CFG, 1, d);
      chk_word("running status", 16'h003E, d);
      for (int r = 0; r < 4; r++)
      begin
         i_mst.wr(DEV, `TCT_CMD_CFG, 1, {12'h000, r[1:0], 2'b10}, ok);
         repeat (330) @(posedge clk);
         i_mst.rd(DEV, `TCT_CMD_RD_TEMP, 2, d);
         m = 16'hFFF0 << (3 - r);
         chk_word("masked result", 16'h19F7 & m, d);
      end
   endtask

   task automatic t_alarm();
      temp <= 16'h4FF0;
      repeat (400) @(posedge clk);
      chk_bit("below high", 1'b0, alarm);
      temp <= 16'h5000;
      repeat (400) @(posedge clk);
      chk_bit("at high", 1'b1, alarm);
      temp <= 16'h4C00;
      repeat (400) @(posedge clk);
      chk_bit("inside band", 1'b1, alarm);
      temp <= 16'h4B00;
      repeat (400) @(posedge clk);
      chk_bit("at low", 1'b0, alarm);
   endtask

   initial
   begin
      rst_n = 1'b0;
      strap = 3'b101;
      temp = 16'h1917;
      error_cnt = 0;
      total_checks = 0;
      do_reset();
      t_defaults();
      t_address();
      t_single();
      t_again();
      t_resolution();
      t_alarm();
      close_out();
   end

   initial
   begin
      repeat (98000) @(posedge clk);
      error_cnt++;
      $display("ERROR watchdog expected finish seen timeout");
      close_out();
   end
endmodule
`default_nettype wire
